// file: pss_pkg.sv
// Shared constants and types for the power state sequencer.
// Assumes a single 50 MHz controller clock for every module that uses it.
package pss_pkg;

	// Controller clock
	localparam int unsigned CLK_HZ            = 50_000_000;
	localparam int unsigned CYCLES_PER_MS     = CLK_HZ / 1000;

	// Pushbutton long-press threshold; the press counts only once exceeded
	localparam int unsigned LONG_PRESS_MS     = 32;
	localparam int unsigned LONG_PRESS_CYCLES = CYCLES_PER_MS * LONG_PRESS_MS;

	// Dwell in sequence start during a power cycle (0.5 s)
	localparam int unsigned PCYCLE_DWELL_MS     = 500;
	localparam int unsigned PCYCLE_DWELL_CYCLES = CYCLES_PER_MS * PCYCLE_DWELL_MS;

	// Rail sequencing delays are programmed in units of this tick
	localparam int unsigned SEQ_TICK_MS     = 1;
	localparam int unsigned SEQ_TICK_CYCLES = CYCLES_PER_MS * SEQ_TICK_MS;
	localparam int unsigned SEQ_DELAY_W     = 8;

	// Rail layout: bucks occupy the low indices, linear regulators follow
	localparam int unsigned NUM_BUCK  = 3;
	localparam int unsigned NUM_LDO   = 2;
	localparam int unsigned NUM_RAILS = NUM_BUCK + NUM_LDO;
	localparam int unsigned LDO1_IDX  = NUM_BUCK;

	// Per-buck sleep selection code
	localparam int unsigned     BUCK_SEL_W  = 2;
	localparam logic [1:0]      SEL_PRIMARY = 2'h0;
	localparam logic [1:0]      SEL_ALTERNATE = 2'h1;
	localparam logic [1:0]      SEL_OFF     = 2'h2;

	// Idle level of the pushbutton pin (released)
	localparam logic            PB_IDLE     = 1'h1;

	// Controller states
	typedef enum logic [2:0] {
		ST_POWER_OFF,
		ST_SEQ_START,
		ST_ACTIVE,
		ST_SLEEP,
		ST_DEEP_SLEEP,
		ST_THERMAL
	} pss_state_t;

	// Reason that sequence start was entered
	typedef enum logic [1:0] {
		ORG_PUSHBUTTON,
		ORG_I2C,
		ORG_PCYCLE,
		ORG_RESUME
	} pss_origin_t;

endpackage : pss_pkg

// file: pss_sync.sv
// Two-flop synchroniser for a bundle of independent asynchronous levels.
// Assumes each bit is a quasi-static level; multi-bit coherence is not kept.
`timescale 1ns/1ps
`default_nettype none
module pss_sync #(
	parameter int unsigned      WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_in,    // Controller clock
	input  wire logic             reset_in,  // Async reset, active high
	input  wire logic [WIDTH-1:0] async_in,  // Levels from outside the domain
	output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} pss_sync_t;

	pss_sync_t sync_reg;
	pss_sync_t sync_next;

	// First stage feeds only the second stage
	always_comb begin
		sync_next.stage1 = async_in;
		sync_next.stage2 = sync_reg.stage1;
	end

	// Reset to the idle level so no false event shows after release
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync_reg <= '{stage1: RESET_VAL, stage2: RESET_VAL};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg.stage2;

endmodule : pss_sync
`default_nettype wire

// file: pss_press_timer.sv
// Pushbutton hold timer: flags a press held longer than a cycle threshold.
// Assumes held_in is already synchronised to clk_in.
`timescale 1ns/1ps
`default_nettype none
module pss_press_timer #(
	parameter int unsigned LIMIT = pss_pkg::LONG_PRESS_CYCLES
) (
	input  wire logic clk_in,               // Controller clock
	input  wire logic reset_in,             // Async reset, active high
	input  wire logic held_in,              // Button held, synchronised
	output logic      long_press_out,       // Held past threshold, level
	output logic      long_press_pulse_out  // First cycle past threshold
);

	localparam int unsigned CNT_W = $clog2(LIMIT + 2);
	localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(LIMIT + 1);

	if (LIMIT < 1) begin : g_bad_limit
		$error("pss_press_timer: LIMIT must be at least one cycle");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             long_press;
		logic             pulse;
	} pss_press_t;

	pss_press_t press_reg;
	pss_press_t press_next;

	// Saturating count while held; a release restarts the measurement
	always_comb begin
		press_next = press_reg;
		press_next.pulse = 1'b0;
		if (!held_in) begin
			press_next.cnt = '0;
			press_next.long_press = 1'b0;
		end else if (press_reg.cnt != CNT_SAT) begin
			press_next.cnt = press_reg.cnt + CNT_W'(1);
			if (press_reg.cnt + CNT_W'(1) == CNT_SAT) begin
				press_next.long_press = 1'b1;
				press_next.pulse = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			press_reg <= '0;
		end else begin
			press_reg <= press_next;
		end
	end

	assign long_press_out       = press_reg.long_press;
	assign long_press_pulse_out = press_reg.pulse;

endmodule : pss_press_timer
`default_nettype wire

// file: pss_state_sequencer.sv
// Master power state controller: power-off, sequence start, active,
// sleep, deep sleep and thermal states, plus per-rail sequenced enables.
// Assumes control bits arrive from a register block on clk_in and that
// regulator status, the pushbutton and the sleep GPIO are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module pss_state_sequencer #(
	parameter int unsigned LONG_PRESS_CYCLES   = pss_pkg::LONG_PRESS_CYCLES,
	parameter int unsigned PCYCLE_DWELL_CYCLES = pss_pkg::PCYCLE_DWELL_CYCLES,
	parameter int unsigned SEQ_TICK_CYCLES     = pss_pkg::SEQ_TICK_CYCLES,
	parameter int unsigned DELAY_W             = pss_pkg::SEQ_DELAY_W,
	parameter bit          SLEEP_COMBINE_OR    = 1'b1
) (
	input  wire logic clk_in,                      // Controller clock
	input  wire logic reset_in,                    // Async reset, active high
	input  wire logic pushbutton_n_in,             // Pushbutton pin, low pressed
	input  wire logic power_off_bit_in,            // Power-off control bit
	input  wire logic sleep_bit_in,                // Sleep control bit
	input  wire logic sleep_gpio_in,               // Sleep control GPIO pin
	input  wire logic sleep_gpio_configured_in,    // GPIO assigned to sleep
	input  wire logic deep_sleep_req_in,           // Deep-sleep entry condition
	input  wire logic power_cycle_req_in,          // Power-cycle request pulse
	input  wire logic thermal_shutdown_in,         // Over-temperature, async
	input  wire logic [pss_pkg::NUM_RAILS-1:0]
		in_regulation_in,                          // Rail in regulation, async
	input  wire logic [pss_pkg::NUM_RAILS-1:0]
		rail_fault_in,                             // Rail fault, async
	input  wire logic [pss_pkg::NUM_RAILS-1:0]
		rail_vin_only_in,                          // Rail sequenced from supply
	input  wire logic [pss_pkg::NUM_RAILS*DELAY_W-1:0]
		rail_delay_in,                             // Sequencing delay, ticks
	input  wire logic [pss_pkg::NUM_BUCK*pss_pkg::BUCK_SEL_W-1:0]
		sleep_buck_sel_in,                         // Buck sleep selection
	input  wire logic [pss_pkg::NUM_LDO-1:0]
		sleep_ldo_on_in,                           // LDO on in sleep
	input  wire logic [pss_pkg::NUM_RAILS-1:0]
		deep_sleep_on_in,                          // Rail on in deep sleep
	input  wire logic ldo1_always_on_in,           // LDO1 kept on in power-off
	output logic [2:0] state_out,                  // Current state code
	output logic [pss_pkg::NUM_RAILS-1:0]
		rail_enable_out,                           // Rail enables
	output logic [pss_pkg::NUM_BUCK-1:0]
		buck_alternate_out,                        // Buck uses alternate setpoint
	output logic sleep_mode_out,                   // Fixed combine select
	output logic i2c_enable_out,                   // I2C engine enabled
	output logic i2c_reset_out,                    // I2C engine reset pulse
	output logic power_off_bit_clear_out,          // Clear power-off bit pulse
	output logic sleep_bit_clear_out               // Clear sleep bit pulse
);

	localparam int unsigned NR      = pss_pkg::NUM_RAILS;
	localparam int unsigned NB      = pss_pkg::NUM_BUCK;
	localparam int unsigned SW      = pss_pkg::BUCK_SEL_W;
	localparam int unsigned DWELL_W = $clog2(PCYCLE_DWELL_CYCLES + 1);
	localparam int unsigned TICK_W  = $clog2(SEQ_TICK_CYCLES + 1);
	localparam logic [DWELL_W-1:0] DWELL_LAST = DWELL_W'(PCYCLE_DWELL_CYCLES - 1);
	localparam logic [TICK_W-1:0]  TICK_LAST  = TICK_W'(SEQ_TICK_CYCLES - 1);
	localparam int unsigned SYNC_W  = 3 + 2 * NR;
	localparam logic [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-1){1'b0}}, pss_pkg::PB_IDLE};

	// Counts of zero leave no time to measure and are refused
	if (LONG_PRESS_CYCLES < 1 || PCYCLE_DWELL_CYCLES < 1 || SEQ_TICK_CYCLES < 1)
	begin : g_bad_count
		$error("pss_state_sequencer: timing counts must be at least one");
	end
	if (DELAY_W < 1) begin : g_bad_width
		$error("pss_state_sequencer: DELAY_W must be at least one");
	end

	typedef struct packed {
		pss_pkg::pss_state_t              state;
		pss_pkg::pss_origin_t             origin;
		logic                             reached;
		logic                             pcycle;
		logic                             recovering;
		logic [DWELL_W-1:0]               dwell;
		logic [TICK_W-1:0]                tick;
		logic [NR-1:0][DELAY_W-1:0]       wait_cnt;
		logic [NR-1:0]                    rail_en;
		logic [NB-1:0]                    buck_alt;
		logic                             i2c_en;
		logic                             i2c_rst;
		logic                             pwroff_clr;
		logic                             sleep_clr;
	} pss_main_t;

	pss_main_t main_reg;
	pss_main_t main_next;

	logic [SYNC_W-1:0] sync_lv;
	logic              pb_level;
	logic              gpio_level;
	logic              thermal;
	logic [NR-1:0]     in_reg;
	logic [NR-1:0]     fault;
	logic              long_press;
	logic              long_pulse;
	logic              sleep_req;
	logic              tick_pulse;
	logic              all_ok;
	logic [NR-1:0]     rail_target;
	logic [NR-1:0]     rail_en_nx;
	logic [NR-1:0][DELAY_W-1:0] wait_nx;
	logic [NB-1:0]     buck_alt_nx;

	// All pin and regulator status levels pass two flops before use
	pss_sync #(
		.WIDTH     (SYNC_W),
		.RESET_VAL (SYNC_RST)
	) u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.async_in ({rail_fault_in, in_regulation_in, thermal_shutdown_in,
			sleep_gpio_in, pushbutton_n_in}),
		.sync_out (sync_lv)
	);

	assign pb_level   = sync_lv[0];
	assign gpio_level = sync_lv[1];
	assign thermal    = sync_lv[2];
	assign in_reg     = sync_lv[3 +: NR];
	assign fault      = sync_lv[3 + NR +: NR];

	// Long-press detection on the synchronised button level
	pss_press_timer #(
		.LIMIT (LONG_PRESS_CYCLES)
	) u_press (
		.clk_in               (clk_in),
		.reset_in             (reset_in),
		.held_in              (pb_level != pss_pkg::PB_IDLE),
		.long_press_out       (long_press),
		.long_press_pulse_out (long_pulse)
	);

	// Sleep entry condition; the combine select is a build constant
	always_comb begin
		if (!sleep_gpio_configured_in) begin
			sleep_req = sleep_bit_in;
		end else if (SLEEP_COMBINE_OR) begin
			sleep_req = sleep_bit_in | gpio_level;
		end else begin
			sleep_req = sleep_bit_in & gpio_level;
		end
	end

	// Shared tick that paces every rail's sequencing delay
	assign tick_pulse = (main_reg.tick == TICK_LAST);

	// Regulation is judged only once enables have settled on their target
	assign all_ok = (&(in_reg | ~rail_target)) && (main_reg.rail_en == rail_target);

	// Per-rail target, delay timing and sleep setpoint selection
	for (genvar i = 0; i < NR; i++) begin : g_rail
		logic                sleep_on;
		logic                skip;
		logic [DELAY_W-1:0]  delay;

		if (i < NB) begin : g_buck
			logic [SW-1:0] sel;
			assign sel = sleep_buck_sel_in[i*SW +: SW];
			// Off code and the unused code both mean off
			assign sleep_on = (sel == pss_pkg::SEL_PRIMARY)
				|| (sel == pss_pkg::SEL_ALTERNATE);
			assign buck_alt_nx[i] = (main_next.state == pss_pkg::ST_SLEEP)
				&& (sel == pss_pkg::SEL_ALTERNATE);
		end else begin : g_ldo
			// No alternate setpoint exists, so only on or off
			assign sleep_on = sleep_ldo_on_in[i - NB];
		end

		always_comb begin
			case (main_reg.state)
				pss_pkg::ST_SEQ_START,
				pss_pkg::ST_ACTIVE:     rail_target[i] = 1'b1;
				pss_pkg::ST_SLEEP:      rail_target[i] = sleep_on;
				pss_pkg::ST_DEEP_SLEEP: rail_target[i] = deep_sleep_on_in[i];
				pss_pkg::ST_POWER_OFF:  rail_target[i] = (i == pss_pkg::LDO1_IDX)
					&& ldo1_always_on_in;
				default:                rail_target[i] = 1'b0;
			endcase
		end

		// Thermal shutdown drops rails at once; supply-only rails return at once
		assign skip = (main_reg.state == pss_pkg::ST_THERMAL)
			|| (main_reg.recovering && rail_vin_only_in[i]);
		assign delay = rail_delay_in[i*DELAY_W +: DELAY_W];

		// Enable follows its target after the programmed number of ticks
		always_comb begin
			rail_en_nx[i] = main_reg.rail_en[i];
			wait_nx[i]    = '0;
			if (rail_target[i] != main_reg.rail_en[i]) begin
				if (skip || main_reg.wait_cnt[i] >= delay) begin
					rail_en_nx[i] = rail_target[i];
				end else if (tick_pulse) begin
					wait_nx[i] = main_reg.wait_cnt[i] + DELAY_W'(1);
				end else begin
					wait_nx[i] = main_reg.wait_cnt[i];
				end
			end
		end
	end

	// State transitions; thermal shutdown overrides every powered state
	always_comb begin
		main_next            = main_reg;
		main_next.i2c_en     = 1'b1;
		main_next.i2c_rst    = 1'b0;
		main_next.pwroff_clr = 1'b0;
		main_next.sleep_clr  = 1'b0;
		main_next.tick       = tick_pulse ? '0 : main_reg.tick + TICK_W'(1);
		main_next.dwell      = '0;
		case (main_reg.state)
			pss_pkg::ST_POWER_OFF: begin
				main_next.reached = 1'b0;
				if (main_reg.pcycle) begin
					main_next.pcycle = 1'b0;
					main_next.origin = pss_pkg::ORG_PCYCLE;
					main_next.state  = pss_pkg::ST_SEQ_START;
				end else if (long_pulse) begin
					// Button start also clears the bit so active is not left again
					main_next.pwroff_clr = 1'b1;
					main_next.origin     = pss_pkg::ORG_PUSHBUTTON;
					main_next.state      = pss_pkg::ST_SEQ_START;
				end else if (!power_off_bit_in) begin
					main_next.origin = pss_pkg::ORG_I2C;
					main_next.state  = pss_pkg::ST_SEQ_START;
				end
			end
			pss_pkg::ST_SEQ_START: begin
				case (main_reg.origin)
					pss_pkg::ORG_PUSHBUTTON: begin
						if (!long_press) begin
							// Released: active only if all rails are in regulation at release
							main_next.state = all_ok ? pss_pkg::ST_ACTIVE
								: pss_pkg::ST_POWER_OFF;
						end else if (main_reg.reached && (|fault)) begin
							main_next.state = pss_pkg::ST_POWER_OFF;
						end else if (all_ok) begin
							main_next.reached = 1'b1;
						end
					end
					pss_pkg::ORG_PCYCLE: begin
						if (main_reg.dwell == DWELL_LAST) begin
							main_next.state = pss_pkg::ST_ACTIVE;
						end else begin
							main_next.dwell = main_reg.dwell + DWELL_W'(1);
						end
					end
					default: begin
						if (all_ok) begin
							main_next.state = pss_pkg::ST_ACTIVE;
						end
					end
				endcase
			end
			pss_pkg::ST_ACTIVE: begin
				main_next.recovering = (main_reg.rail_en != rail_target)
					&& main_reg.recovering;
				if (power_off_bit_in) begin
					main_next.state = pss_pkg::ST_POWER_OFF;
				end else if (power_cycle_req_in) begin
					// Pass briefly through power-off, then dwell in start
					main_next.pcycle = 1'b1;
					main_next.state  = pss_pkg::ST_POWER_OFF;
				end else if (deep_sleep_req_in) begin
					main_next.state = pss_pkg::ST_DEEP_SLEEP;
				end else if (sleep_req) begin
					main_next.state = pss_pkg::ST_SLEEP;
				end
			end
			pss_pkg::ST_SLEEP: begin
				if (long_pulse) begin
					main_next.sleep_clr = 1'b1;
					main_next.origin    = pss_pkg::ORG_RESUME;
					main_next.state     = pss_pkg::ST_SEQ_START;
				end else if (!sleep_req) begin
					main_next.origin = pss_pkg::ORG_RESUME;
					main_next.state  = pss_pkg::ST_SEQ_START;
				end
			end
			pss_pkg::ST_DEEP_SLEEP: begin
				if (!deep_sleep_req_in) begin
					main_next.origin = pss_pkg::ORG_RESUME;
					main_next.state  = pss_pkg::ST_SEQ_START;
				end
			end
			pss_pkg::ST_THERMAL: begin
				if (!thermal) begin
					main_next.recovering = 1'b1;
					main_next.state      = pss_pkg::ST_ACTIVE;
				end
			end
			default: begin
				main_next.state = pss_pkg::ST_POWER_OFF;
			end
		endcase
		if (thermal && main_reg.state != pss_pkg::ST_POWER_OFF) begin
			main_next.recovering = 1'b0;
			main_next.state      = pss_pkg::ST_THERMAL;
		end
		// One-cycle engine reset on entry to the low-power and thermal states
		if (main_next.state != main_reg.state
			&& (main_next.state == pss_pkg::ST_SLEEP
			|| main_next.state == pss_pkg::ST_DEEP_SLEEP
			|| main_next.state == pss_pkg::ST_THERMAL)) begin
			main_next.i2c_rst = 1'b1;
		end
		main_next.rail_en  = rail_en_nx;
		main_next.wait_cnt = wait_nx;
		main_next.buck_alt = buck_alt_nx;
	end

	// Power-off with all rails down is the safe reset state
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			main_reg <= '{state: pss_pkg::ST_POWER_OFF,
				origin: pss_pkg::ORG_I2C, default: '0};
		end else begin
			main_reg <= main_next;
		end
	end

	// Outputs straight from the state register, except the combine select, which is the build constant
	assign state_out               = main_reg.state;
	assign rail_enable_out         = main_reg.rail_en;
	assign buck_alternate_out      = main_reg.buck_alt;
	assign sleep_mode_out          = SLEEP_COMBINE_OR;
	assign i2c_enable_out          = main_reg.i2c_en;
	assign i2c_reset_out           = main_reg.i2c_rst;
	assign power_off_bit_clear_out = main_reg.pwroff_clr;
	assign sleep_bit_clear_out     = main_reg.sleep_clr;

endmodule : pss_state_sequencer
`default_nettype wire

// file: pss_chk.sv
// Output checker for the power state sequencer.
// Assumes it is bound into pss_state_sequencer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pss_chk #(
	parameter bit SLEEP_COMBINE_OR = 1'b1
) (
	input wire logic                          clk_in,                   // Clock
	input wire logic                          reset_in,                 // Reset
	input wire logic                          sleep_bit_in,             // Sleep bit
	input wire logic                          sleep_gpio_configured_in, // GPIO used
	input wire logic [2:0]                    state_out,                // State
	input wire logic [pss_pkg::NUM_RAILS-1:0] rail_enable_out,          // Enables
	input wire logic [pss_pkg::NUM_BUCK-1:0]  buck_alternate_out,       // Alt setpoint
	input wire logic                          sleep_mode_out,           // Combine
	input wire logic                          i2c_enable_out,           // I2C on
	input wire logic                          i2c_reset_out,            // I2C reset
	input wire logic                          power_off_bit_clear_out,  // Clear pulse
	input wire logic                          sleep_bit_clear_out       // Clear pulse
);
	localparam logic [2:0] SEQ = pss_pkg::ST_SEQ_START;
	localparam logic [2:0] ACT = pss_pkg::ST_ACTIVE;
	localparam logic [2:0] SLP = pss_pkg::ST_SLEEP;
	localparam logic [2:0] THM = pss_pkg::ST_THERMAL;

	// All checks share one clock and reset
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	chk_mode_fixed: assert property (sleep_mode_out == SLEEP_COMBINE_OR)
		else $error("combine select differs from build value");
	chk_i2c_sleep_on: assert property (state_out == SLP |-> i2c_enable_out)
		else $error("i2c disabled in sleep");
	chk_i2c_rst_entry: assert property (($changed(state_out) && (state_out == SLP ||
		state_out == THM)) |-> (i2c_reset_out || $past(i2c_reset_out)))
		else $error("no i2c reset on low power entry");
	chk_i2c_rst_pulse: assert property (i2c_reset_out |=> !i2c_reset_out)
		else $error("i2c reset longer than one cycle");
	chk_alt_only_sleep: assert property ((buck_alternate_out != 3'h0) |-> state_out == SLP)
		else $error("alternate setpoint outside sleep");
	chk_sleep_clr_exit: assert property (sleep_bit_clear_out |-> ##[0:2] state_out != SLP)
		else $error("long press did not leave sleep");
	chk_poff_clr_start: assert property (power_off_bit_clear_out |-> ##[0:1] state_out == SEQ)
		else $error("clear pulse without sequence start");
	chk_thermal_rails: assert property (state_out == THM [*2] |-> rail_enable_out == 5'h00)
		else $error("rails on in thermal");
	chk_sleep_bit_exit: assert property ((state_out == SLP && !sleep_gpio_configured_in
		&& !sleep_bit_in) |=> state_out != SLP)
		else $error("sleep held with entry false");
	chk_bit_only_entry: assert property ((state_out == ACT && !sleep_gpio_configured_in
		&& !sleep_bit_in) |=> state_out != SLP)
		else $error("sleep entered with bit clear");
endmodule : pss_chk
`default_nettype wire

// file: pss_rail_model.sv
// Regulator model: each rail reaches regulation two cycles after enable.
// Assumes faults come from the bench and pull the rail out of regulation.
`timescale 1ns/1ps
`default_nettype none
module pss_rail_model (
	input  wire logic       clk_in,     // Clock
	input  wire logic       reset_in,   // Reset
	input  wire logic [4:0] enable_in,  // Rail enables
	input  wire logic [4:0] fault_in,   // Forced faults
	output logic      [4:0] in_reg_out  // In regulation
);
	logic [4:0] lag_reg;

	// Soft-start lag so regulation never coincides with enable
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lag_reg    <= 5'h00;
			in_reg_out <= 5'h00;
		end else begin
			lag_reg    <= enable_in;
			in_reg_out <= lag_reg & enable_in & ~fault_in;
		end
	end
endmodule : pss_rail_model
`default_nettype wire

// file: test_pmic_state_sequencer.sv
// Self-checking bench for the power state sequencer.
// Assumes short counts: long press 20, dwell 50, tick 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_pmic_state_sequencer;
	localparam logic [2:0] OFF = pss_pkg::ST_POWER_OFF;
	localparam logic [2:0] SEQ = pss_pkg::ST_SEQ_START;
	localparam logic [2:0] ACT = pss_pkg::ST_ACTIVE;
	localparam logic [2:0] SLP = pss_pkg::ST_SLEEP;
	localparam logic [2:0] THM = pss_pkg::ST_THERMAL;
	localparam logic [2:0] DSL = pss_pkg::ST_DEEP_SLEEP;
	logic       clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic       pb_n = 1'b1;
	logic       po_bit = 1'b1;
	logic       slp_bit = 1'b0;
	logic       gpio = 1'b0;
	logic       gpio_cfg = 1'b0;
	logic       pcyc = 1'b0;
	logic       therm = 1'b0;
	logic       ds_req = 1'b0;
	logic       ldo1_on = 1'b1;
	logic [4:0] ds_on = 5'h00;
	logic       seen_rst = 1'b0;
	logic [4:0] fault = 5'h00;
	logic [4:0] vin_only = 5'h03;
	logic [7:0] dly = 8'h03;
	logic [4:0] inreg, rails;
	logic [2:0] st, alt;
	logic       smode, i2c_en, i2c_rst, po_clr, slp_clr;
	int         fails = 0;
	int         n_checks = 0;
	int         cyc = 0;
	int         n;

	pss_state_sequencer #(.LONG_PRESS_CYCLES(20), .PCYCLE_DWELL_CYCLES(50),
		.SEQ_TICK_CYCLES(4)) uut (
		.clk_in(clk_in), .reset_in(reset_in), .pushbutton_n_in(pb_n),
		.power_off_bit_in(po_bit), .sleep_bit_in(slp_bit), .sleep_gpio_in(gpio),
		.sleep_gpio_configured_in(gpio_cfg), .deep_sleep_req_in(ds_req),
		.power_cycle_req_in(pcyc), .thermal_shutdown_in(therm), .in_regulation_in(inreg),
		.rail_fault_in(fault), .rail_vin_only_in(vin_only), .rail_delay_in({5{dly}}),
		.sleep_buck_sel_in(6'h21), .sleep_ldo_on_in(2'h1), .deep_sleep_on_in(ds_on),
		.ldo1_always_on_in(ldo1_on), .state_out(st), .rail_enable_out(rails),
		.buck_alternate_out(alt), .sleep_mode_out(smode), .i2c_enable_out(i2c_en),
		.i2c_reset_out(i2c_rst), .power_off_bit_clear_out(po_clr),
		.sleep_bit_clear_out(slp_clr));
	pss_rail_model partner (.clk_in(clk_in), .reset_in(reset_in), .enable_in(rails),
		.fault_in(fault), .in_reg_out(inreg));

	// Clock
	initial begin
		forever #10 clk_in = ~clk_in;
	end

	// Register block clears bits on request; cycle ceiling cuts hangs
	always @(posedge clk_in) begin
		if (po_clr === 1'b1) po_bit <= 1'b0;
		if (slp_clr === 1'b1) slp_bit <= 1'b0;
		if (i2c_rst === 1'b1) seen_rst <= 1'b1;
		cyc++;
		if (cyc > 10000) begin
			fails++;
			$display("[FAIL] %0t timeout", $time);
			results();
		end
	end

	task automatic tk(input int k);
		repeat (k) @(posedge clk_in);
	endtask : tk
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t %s (state %0d)", $time, m, st);
		end
	endtask : chk
	task automatic wait_st(input logic [2:0] s, input int k);
		for (int i = 0; i < k && st !== s; i++) @(posedge clk_in);
		chk(st === s, "state not reached");
	endtask : wait_st
	task automatic t_i2c_start();
		chk(st === OFF, "not off after reset");
		tk(30);
		chk(rails === 5'h08, "ldo1 not kept on in off");
		po_bit <= 1'b0;
		wait_st(SEQ, 10);
		wait_st(ACT, 200);
		chk(rails === 5'h1F, "rails not on");
		$display("i2c start done");
	endtask : t_i2c_start
	task automatic t_thermal();
		seen_rst <= 1'b0;
		therm <= 1'b1;
		wait_st(THM, 10);
		tk(3);
		chk(rails === 5'h00 && seen_rst === 1'b1, "thermal entry");
		therm <= 1'b0;
		wait_st(ACT, 10);
		tk(2);
		chk(rails === vin_only, "supply rails only");
		tk(40);
		chk(rails === 5'h1F, "dependent rails late");
		$display("thermal done");
	endtask : t_thermal
	task automatic t_sleep();
		seen_rst <= 1'b0;
		slp_bit <= 1'b1;
		wait_st(SLP, 5);
		tk(60);
		chk(rails === 5'h0B && seen_rst === 1'b1, "sleep rails");
		chk(alt === 3'h1 && smode === 1'b1 && i2c_en === 1'b1, "sleep setpoints");
		gpio_cfg <= 1'b1;
		gpio <= 1'b1;
		tk(3); // GPIO pin is synchronised before it can hold sleep
		slp_bit <= 1'b0;
		tk(6);
		chk(st === SLP, "gpio alone should hold sleep");
		gpio <= 1'b0;
		wait_st(SEQ, 6);
		wait_st(ACT, 200);
		gpio_cfg <= 1'b0;
		$display("sleep done");
	endtask : t_sleep
	task automatic t_sleep_press();
		slp_bit <= 1'b1;
		wait_st(SLP, 5);
		pb_n <= 1'b0;
		tk(10);
		chk(st === SLP, "short press left sleep");
		wait_st(SEQ, 40);
		tk(1);
		chk(slp_bit === 1'b0, "sleep bit kept");
		pb_n <= 1'b1;
		wait_st(ACT, 200);
		$display("sleep press done");
	endtask : t_sleep_press
	task automatic t_deep();
		seen_rst <= 1'b0;
		ds_on <= 5'h11;
		ds_req <= 1'b1;
		wait_st(DSL, 5);
		tk(40);
		chk(rails === 5'h11 && seen_rst === 1'b1, "deep sleep rails");
		ds_req <= 1'b0;
		wait_st(ACT, 200);
		$display("deep sleep done");
	endtask : t_deep
	task automatic t_pcycle();
		pcyc <= 1'b1;
		tk(1);
		pcyc <= 1'b0;
		wait_st(OFF, 6);
		wait_st(SEQ, 4);
		for (n = 0; n < 200 && st === SEQ; n++) @(posedge clk_in);
		chk(st === ACT && n >= 49 && n <= 51, "dwell length");
		$display("power cycle done");
	endtask : t_pcycle
	task automatic pb_go(input logic [7:0] d);
		po_bit <= 1'b1;
		wait_st(OFF, 6);
		tk(30); // Rails drain first so the start begins from power-off levels
		dly <= d;
		pb_n <= 1'b0;
		wait_st(SEQ, 40);
		tk(2);
		chk(po_bit === 1'b0, "power-off bit kept");
	endtask : pb_go
	task automatic t_pb_ok();
		pb_go(8'h03);
		tk(40);
		chk(st === SEQ, "left start while held");
		pb_n <= 1'b1;
		wait_st(ACT, 8);
		$display("button start done");
	endtask : t_pb_ok
	task automatic t_pb_early();
		pb_go(8'h20);
		pb_n <= 1'b1;
		wait_st(OFF, 8);
		dly <= 8'h03;
		wait_st(ACT, 300);
		$display("early release done");
	endtask : t_pb_early
	task automatic t_pb_fault();
		pb_go(8'h03);
		tk(40);
		fault <= 5'h04;
		wait_st(OFF, 8);
		fault <= 5'h00;
		pb_n <= 1'b1;
		wait_st(ACT, 300);
		$display("fault start done");
	endtask : t_pb_fault
	task automatic results();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	// Main sequence
	initial begin
		tk(4);
		reset_in <= 1'b0;
		tk(2);
		t_i2c_start();
		t_thermal();
		t_sleep();
		t_sleep_press();
		t_deep();
		t_pcycle();
		t_pb_ok();
		t_pb_early();
		t_pb_fault();
		results();
	end
endmodule : test_pmic_state_sequencer

bind pss_state_sequencer pss_chk #(.SLEEP_COMBINE_OR(SLEEP_COMBINE_OR)) chk_i (
	.clk_in(clk_in), .reset_in(reset_in), .sleep_bit_in(sleep_bit_in),
	.sleep_gpio_configured_in(sleep_gpio_configured_in), .state_out(state_out),
	.rail_enable_out(rail_enable_out), .buck_alternate_out(buck_alternate_out),
	.sleep_mode_out(sleep_mode_out), .i2c_enable_out(i2c_enable_out),
	.i2c_reset_out(i2c_reset_out), .power_off_bit_clear_out(power_off_bit_clear_out),
	.sleep_bit_clear_out(sleep_bit_clear_out));
`default_nettype wire
